//--- irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  // Clock
  input  wire logic       mclk_i,
  // Device requests, two devices per external line
  input  wire logic [7:0] ext_src_i,
  input  wire logic       pwr_src_i,
  input  wire logic       mchk_src_i,
  input  wire logic       halt_src_i,
  // Request pins
  output logic      [3:0] ext_irq_o = 4'h0,
  output logic            pwr_fail_irq_o = 1'b0,
  output logic            mch_chk_irq_o = 1'b0,
  output logic            halt_irq_o = 1'b0
);
  // Same-level devices share one pin; a device may drop before service
  always @(posedge mclk_i) begin
    ext_irq_o      <= ext_src_i[3:0] | ext_src_i[7:4];
    pwr_fail_irq_o <= pwr_src_i;
    mch_chk_irq_o  <= mchk_src_i;
    halt_irq_o     <= halt_src_i;
  end
endmodule : irq_source_model
`default_nettype wire

//--- level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH  = 7,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  if (STAGES < 2) begin : g_bad_stages
    $error("level_sync needs at least two stages");
  end

  // One chain per bit; only the last stage is visible outside
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    logic [STAGES-1:0] chain_q;
    always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
        chain_q <= '0;
      end else begin
        chain_q <= {chain_q[STAGES-2:0], async_i[b]};
      end
    end
    assign sync_o[b] = chain_q[STAGES-1];
  end

endmodule : level_sync
`default_nettype wire

//--- priority_interrupt_pkg.sv
`default_nettype none
package priority_interrupt_pkg;

  // Internal register indices, used as the move instruction selector
  localparam int             IDX_W          = 12;
  localparam logic [11:0]    IDX_SUMMARY    = 12'h100;
  localparam logic [11:0]    IDX_SOFT_REQ   = 12'h108;
  localparam logic [11:0]    IDX_AST_REQ    = 12'h109;
  localparam logic [11:0]    IDX_AST_EN     = 12'h10A;
  localparam logic [11:0]    IDX_EXCEPTION_RETURN_ADDRESS   = 12'h10B;
  localparam logic [11:0]    IDX_CUR_LEVEL  = 12'h110;
  localparam logic [11:0]    IDX_INT_ID     = 12'h111;
  localparam logic [11:0]    IDX_HW_CLEAR   = 12'h115;
  localparam logic [11:0]    IDX_FETCH_CSR  = 12'h118;

  localparam int             DATA_W         = 64;
  localparam int             LEVEL_W        = 5;
  localparam int             ID_W           = 6;

  // Target levels of the fixed sources
  localparam int             LVL_SOFT_MAX   = 15;
  localparam logic [4:0]     LVL_AST        = 5'h02;
  localparam int             LVL_EXT_BASE   = 20;
  localparam int             EXT_LINES      = 4;
  localparam logic [4:0]     LVL_PERF       = 5'h1D;
  localparam logic [4:0]     LVL_PWR        = 5'h1E;
  localparam logic [4:0]     LVL_MCHK       = 5'h1F;

  // Identification codes for the two sources with no target level
  localparam logic [5:0]     ID_HALT        = 6'h20;
  localparam logic [5:0]     ID_SERIAL      = 6'h21;

  // Field positions
  localparam int             CSR_EXT_EN_LSB = 8;
  localparam int             SUM_HALT_BIT   = 32;
  localparam int             SUM_SERIAL_BIT = 33;
  localparam int             SUM_AST_BIT    = 34;
  localparam int             CLR_PERF_BIT   = 0;
  localparam int             CLR_SERIAL_BIT = 1;
  localparam int             AST_MODES      = 4;

  // Pins and synchroniser depth
  localparam int             IRQ_PINS       = 7;
  localparam int             SYNC_STAGES    = 2;

  localparam logic [63:0]    RDATA_RESET    = 64'h0;

  typedef enum logic [0:0] {
    S_IDLE,
    S_DRAIN
  } deliver_state_t;

endpackage : priority_interrupt_pkg
`default_nettype wire

//--- priority_interrupt_unit.sv
// Operation
// - seven request pins; while reset is held they are captured as clock straps
// - a source is enabled only when current level is below its target
// - software requests at own number, async trap at 2, perf counter at 29
// - power-fail pin at level 30, machine check pin or internal at 31
// - external lines 0..3 at levels 20..23, each with its own enable bit
// - halt and serial line blocked only in privileged firmware mode
// - delivery only outside privileged firmware mode, otherwise it waits
// - pipeline fully drained before vectoring to the dispatch address
// - on take, restart address saved and privileged mode entered
// - cause readable via identification and summary registers
// - level requests may vanish before service; tolerate that
// - internal registers keep their contents across reset
// - registers reachable only by privileged move instructions by index
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_unit
  import priority_interrupt_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  // Request pins
  input  wire logic [3:0]        ext_irq_i,
  input  wire logic              pwr_fail_irq_i,
  input  wire logic              mch_chk_irq_i,
  input  wire logic              halt_irq_i,
  // Internal sources
  input  wire logic              perf_cnt_irq_i,
  input  wire logic              serial_line_irq_i,
  input  wire logic              internal_mchk_i,
  input  wire logic [1:0]        cur_mode_i,
  // Pipeline and exception logic
  input  wire logic              pipe_drained_i,
  input  wire logic [63:0]       restart_pc_i,
  input  wire logic              fw_return_i,
  output logic                   drain_req_o,
  output logic                   intr_take_o,
  output logic                   privileged_firmware_mode_o,
  // Clock straps
  output logic [6:0]             cfg_straps_o,
  // Move to/from internal register
  input  wire logic              ipr_wr_i,
  input  wire logic              ipr_rd_i,
  input  wire logic [11:0]       ipr_idx_i,
  input  wire logic [63:0]       ipr_wdata_i,
  output logic [63:0]            ipr_rdata_o,
  output logic                   ipr_rd_valid_o
);

  deliver_state_t       state_q;
  logic                 pfm_q;
  logic [15:1]          soft_req_q;
  logic [AST_MODES-1:0] ast_req_q;
  logic [AST_MODES-1:0] ast_en_q;
  logic [63:0]          exception_return_address_q;
  logic [4:0]           ipl_q;
  logic [5:0]           interrupt_identification_q;
  logic [3:0]           ext_en_q;
  logic                 perf_q;
  logic                 serial_q;
  logic [6:0]           pins_s;
  logic [3:0]           ext_s;
  logic                 pwr_s;
  logic                 mchk_s;
  logic                 halt_s;
  logic                 ast_pend;
  logic [31:0]          req_lvl;
  logic                 lvl_found;
  logic [4:0]           top_lvl;
  logic                 any_pend;
  logic [5:0]           next_id;
  logic                 wr_ok;
  logic                 rd_ok;
  logic [63:0]          summary;
  logic [63:0]          rd_mux;

  // Strap capture on the raw pins; synchroniser covers normal use
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cfg_straps_o <= {halt_irq_i, mch_chk_irq_i, pwr_fail_irq_i,
                       ext_irq_i};
    end
  end

  level_sync #(
    .WIDTH  (IRQ_PINS),
    .STAGES (SYNC_STAGES)
  ) u_pin_sync (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .async_i ({halt_irq_i, mch_chk_irq_i, pwr_fail_irq_i, ext_irq_i}),
    .sync_o  (pins_s)
  );

  assign ext_s  = pins_s[3:0];
  assign pwr_s  = pins_s[4];
  assign mchk_s = pins_s[5];
  assign halt_s = pins_s[6];

  // Only privileged firmware may move to or from these registers
  assign wr_ok = ipr_wr_i && pfm_q;
  assign rd_ok = ipr_rd_i && pfm_q;

  // Trap pending for the current or a more privileged mode
  always_comb begin
    ast_pend = 1'b0;
    for (int m = 0; m < AST_MODES; m++) begin
      if (m <= int'(cur_mode_i) && ast_req_q[m] && ast_en_q[m]) begin
        ast_pend = 1'b1;
      end
    end
  end

  always_comb begin
    req_lvl                = '0;
    req_lvl[LVL_SOFT_MAX:1] = soft_req_q;
    req_lvl[LVL_AST]       = soft_req_q[LVL_AST] | ast_pend;
    req_lvl[LVL_EXT_BASE +: EXT_LINES] = ext_s & ext_en_q;
    req_lvl[LVL_PERF]      = perf_q;
    req_lvl[LVL_PWR]       = pwr_s;
    req_lvl[LVL_MCHK]      = mchk_s | internal_mchk_i;
  end

  // Highest level strictly above the current one wins
  always_comb begin
    lvl_found = 1'b0;
    top_lvl   = '0;
    for (int i = 1; i < 32; i++) begin
      if (req_lvl[i] && (5'(i) > ipl_q)) begin
        lvl_found = 1'b1;
        top_lvl   = 5'(i);
      end
    end
  end

  // Halt outranks levels; serial line only fills a gap
  always_comb begin
    if (halt_s) begin
      next_id = ID_HALT;
    end else if (lvl_found) begin
      next_id = {1'b0, top_lvl};
    end else begin
      next_id = ID_SERIAL;
    end
  end

  assign any_pend = halt_s || lvl_found || serial_q;

  // Delivery sequence; a withdrawn request abandons the drain
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q     <= S_IDLE;
      drain_req_o <= 1'b0;
      intr_take_o <= 1'b0;
    end else begin
      intr_take_o <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (any_pend && !pfm_q) begin
            state_q     <= S_DRAIN;
            drain_req_o <= 1'b1;
          end
        end
        S_DRAIN: begin
          if (!any_pend) begin
            state_q     <= S_IDLE;
            drain_req_o <= 1'b0;
          end else if (pipe_drained_i) begin
            state_q     <= S_IDLE;
            drain_req_o <= 1'b0;
            intr_take_o <= 1'b1;
          end
        end
        default: begin
          state_q     <= S_IDLE;
          drain_req_o <= 1'b0;
        end
      endcase
    end
  end

  wire take_now = (state_q == S_DRAIN) && any_pend && pipe_drained_i;

  // Firmware mode: set on reset and on take, left by return if bit 0 of the return address is clear
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pfm_q <= 1'b1;
    end else if (take_now) begin
      pfm_q <= 1'b1;
    end else if (fw_return_i) begin
      pfm_q <= exception_return_address_q[0];
    end
  end

  assign privileged_firmware_mode_o = pfm_q;

  // Hardware save beats a software write in the same cycle
  always_ff @(posedge mclk_i) begin
    if (take_now) begin
      exception_return_address_q <= {restart_pc_i[63:1], 1'b0};
      interrupt_identification_q    <= next_id;
    end else if (wr_ok && ipr_idx_i == IDX_EXCEPTION_RETURN_ADDRESS) begin
      exception_return_address_q <= ipr_wdata_i;
    end
  end

  // Software registers keep contents across reset
  always_ff @(posedge mclk_i) begin
    if (wr_ok) begin
      case (ipr_idx_i)
        IDX_SOFT_REQ:  soft_req_q <= ipr_wdata_i[15:1];
        IDX_AST_REQ:   ast_req_q  <= ipr_wdata_i[AST_MODES-1:0];
        IDX_AST_EN:    ast_en_q   <= ipr_wdata_i[AST_MODES-1:0];
        IDX_CUR_LEVEL: ipl_q      <= ipr_wdata_i[LEVEL_W-1:0];
        IDX_FETCH_CSR: ext_en_q   <= ipr_wdata_i[CSR_EXT_EN_LSB +: 4];
        default: ;
      endcase
    end
  end

  // Sticky internal events; a new event beats the clear
  wire hw_clr = wr_ok && (ipr_idx_i == IDX_HW_CLEAR);
  always_ff @(posedge mclk_i) begin
    if (perf_cnt_irq_i) begin
      perf_q <= 1'b1;
    end else if (hw_clr && ipr_wdata_i[CLR_PERF_BIT]) begin
      perf_q <= 1'b0;
    end
    if (serial_line_irq_i) begin
      serial_q <= 1'b1;
    end else if (hw_clr && ipr_wdata_i[CLR_SERIAL_BIT]) begin
      serial_q <= 1'b0;
    end
  end

  // Raw requests by level, before the current level is applied
  always_comb begin
    summary                 = '0;
    summary[31:0]           = req_lvl;
    summary[SUM_HALT_BIT]   = halt_s;
    summary[SUM_SERIAL_BIT] = serial_q;
    summary[SUM_AST_BIT]    = ast_pend;
  end

  always_comb begin
    rd_mux = '0;
    case (ipr_idx_i)
      IDX_SUMMARY:   rd_mux = summary;
      IDX_SOFT_REQ:  rd_mux[15:1] = soft_req_q;
      IDX_AST_REQ:   rd_mux[AST_MODES-1:0] = ast_req_q;
      IDX_AST_EN:    rd_mux[AST_MODES-1:0] = ast_en_q;
      IDX_EXCEPTION_RETURN_ADDRESS:  rd_mux = exception_return_address_q;
      IDX_CUR_LEVEL: rd_mux[LEVEL_W-1:0] = ipl_q;
      IDX_INT_ID:    rd_mux[ID_W-1:0] = interrupt_identification_q;
      IDX_FETCH_CSR: rd_mux[CSR_EXT_EN_LSB +: 4] = ext_en_q;
      default:       rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      ipr_rdata_o    <= RDATA_RESET;
      ipr_rd_valid_o <= 1'b0;
    end else begin
      ipr_rd_valid_o <= rd_ok;
      if (rd_ok) begin
        ipr_rdata_o <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  property p_straps;
    @(posedge mclk_i) disable iff (1'b0)
    !nrst_i |=> cfg_straps_o == $past({halt_irq_i, mch_chk_irq_i,
                                       pwr_fail_irq_i, ext_irq_i});
  endproperty
  a_straps: assert property (p_straps)
    else $error("strap capture mismatch");

  property p_level_above;
    intr_take_o && !interrupt_identification_q[5] |-> interrupt_identification_q[4:0] > $past(ipl_q);
  endproperty
  a_level_above: assert property (p_level_above)
    else $error("taken level not above current level");

  property p_perf_level;
    state_q == S_IDLE && !pfm_q && perf_q && ipl_q < LVL_PERF
      |=> state_q == S_DRAIN;
  endproperty
  a_perf_level: assert property (p_perf_level)
    else $error("perf counter request not started");

  property p_pwr_level;
    state_q == S_IDLE && !pfm_q && pwr_s && ipl_q < LVL_PWR
      |=> drain_req_o;
  endproperty
  a_pwr_level: assert property (p_pwr_level)
    else $error("power-fail request not started");

  property p_ext_mask;
    intr_take_o && interrupt_identification_q >= 6'd20 && interrupt_identification_q <= 6'd23
      |-> ext_en_q[interrupt_identification_q[1:0]];
  endproperty
  a_ext_mask: assert property (p_ext_mask)
    else $error("masked external line taken");

  property p_halt_any_level;
    state_q == S_IDLE && !pfm_q && halt_s |=> state_q == S_DRAIN;
  endproperty
  a_halt_any_level: assert property (p_halt_any_level)
    else $error("halt not started outside firmware");

  property p_fw_blocks;
    pfm_q && !fw_return_i |=> state_q == S_IDLE && !intr_take_o;
  endproperty
  a_fw_blocks: assert property (p_fw_blocks)
    else $error("delivery while in firmware mode");

  property p_drained;
    intr_take_o |-> $past(pipe_drained_i) && $past(drain_req_o);
  endproperty
  a_drained: assert property (p_drained)
    else $error("take without drained pipeline");

  property p_save;
    intr_take_o |-> pfm_q && exception_return_address_q[63:1] == $past(restart_pc_i[63:1]);
  endproperty
  a_save: assert property (p_save)
    else $error("restart address or mode not saved");

  property p_withdraw;
    state_q == S_DRAIN && !any_pend |=> state_q == S_IDLE && !intr_take_o;
  endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("withdrawn request still taken");

  property p_priv_only;
    ipr_wr_i && !pfm_q && ipr_idx_i == IDX_CUR_LEVEL |=> $stable(ipl_q);
  endproperty
  a_priv_only: assert property (p_priv_only)
    else $error("unprivileged write changed level");

  property p_sync_depth;
    // Chain is flushed by reset, so both stages must have run since
    $past(nrst_i) && $past(nrst_i, 2) |-> pins_s[3:0] == $past(ext_irq_i, 2);
  endproperty
  a_sync_depth: assert property (p_sync_depth)
    else $error("pin synchroniser depth wrong");

endmodule : priority_interrupt_unit
`default_nettype wire

//--- priority_interrupt_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_unit_tb;
  import priority_interrupt_pkg::*;
  typedef struct {int tgt; int cur; bit take;} row_t;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] ext_src = 8'h00;
  logic pwr_src = 1'b0, mchk_src = 1'b0, halt_src = 1'b0;
  logic perf = 1'b0, serial = 1'b0, drained = 1'b0, fw_ret = 1'b0;
  logic imchk = 1'b0;
  logic wr = 1'b0, rd = 1'b0;
  logic [11:0] idx = 12'h000;
  logic [63:0] wdata = 64'h0, pc = 64'h0, rdata;
  logic [3:0] ext_irq;
  logic pwr_irq, mchk_irq, halt_irq, drain_req, take, fw_mode, rd_valid;
  logic [6:0] straps;
  int n_errors = 0;
  int n_compared = 0;
  row_t rows [19] = '{'{34,30,1}, '{20,19,1}, '{20,20,0}, '{21,0,1},
    '{22,21,1},
    '{23,23,0}, '{23,22,1}, '{30,29,1}, '{30,30,0}, '{31,30,1},
    '{29,28,1}, '{29,29,0}, '{15,14,1}, '{15,15,0}, '{1,0,1},
    '{1,1,0}, '{2,1,1}, '{2,2,0}, '{33,31,1}};

  always #20 mclk_i = ~mclk_i;

  irq_source_model u_irq_source_model (.mclk_i(mclk_i),
    .ext_src_i(ext_src), .pwr_src_i(pwr_src), .mchk_src_i(mchk_src),
    .halt_src_i(halt_src), .ext_irq_o(ext_irq), .pwr_fail_irq_o(pwr_irq),
    .mch_chk_irq_o(mchk_irq), .halt_irq_o(halt_irq));

  priority_interrupt_unit u_priority_interrupt_unit (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .ext_irq_i(ext_irq), .pwr_fail_irq_i(pwr_irq),
    .mch_chk_irq_i(mchk_irq), .halt_irq_i(halt_irq),
    .perf_cnt_irq_i(perf), .serial_line_irq_i(serial),
    .internal_mchk_i(imchk), .cur_mode_i(2'b00),
    .pipe_drained_i(drained), .restart_pc_i(pc), .fw_return_i(fw_ret),
    .drain_req_o(drain_req), .intr_take_o(take),
    .privileged_firmware_mode_o(fw_mode), .cfg_straps_o(straps),
    .ipr_wr_i(wr), .ipr_rd_i(rd), .ipr_idx_i(idx), .ipr_wdata_i(wdata),
    .ipr_rdata_o(rdata), .ipr_rd_valid_o(rd_valid));

  task automatic chk(input string name, input logic [63:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask : chk

  task automatic test_done;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic wr_reg(input logic [11:0] i, input logic [63:0] d);
    @(posedge mclk_i);
    wr <= 1'b1;
    idx <= i;
    wdata <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] i, input logic ok,
                        output logic [63:0] d);
    @(posedge mclk_i);
    rd <= 1'b1;
    idx <= i;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    chk("read valid", 64'(ok), 64'(rd_valid));
    d = rdata;
  endtask : rd_reg

  // Pins through the partner; internal sources set while in firmware
  task automatic src(input int t, input logic v);
    @(posedge mclk_i);
    if (t >= 20 && t <= 23) ext_src[t-20+4*(t%2)] <= v;
    else if (t == 30) pwr_src <= v;
    else if (t == 31) mchk_src <= v;
    else if (t == 32) halt_src <= v;
    else if (t == 34) imchk <= v;
    else if (v && (t == 29 || t == 33)) begin
      perf <= (t == 29);
      serial <= (t == 33);
      @(posedge mclk_i);
      perf <= 1'b0;
      serial <= 1'b0;
    end else if (v && t == 2) begin
      wr_reg(IDX_AST_REQ, 64'h1);
      wr_reg(IDX_AST_EN, 64'h1);
    end else if (v) wr_reg(IDX_SOFT_REQ, 64'h1 << t);
  endtask : src

  task automatic setup(input logic [4:0] lvl, input logic [3:0] en);
    wr_reg(IDX_SOFT_REQ, 64'h0);
    wr_reg(IDX_AST_REQ, 64'h0);
    wr_reg(IDX_AST_EN, 64'h0);
    wr_reg(IDX_HW_CLEAR, 64'h3);
    wr_reg(IDX_FETCH_CSR, {52'h0, en, 8'h00});
    wr_reg(IDX_CUR_LEVEL, {59'h0, lvl});
    wr_reg(IDX_EXCEPTION_RETURN_ADDRESS, 64'h0);
  endtask : setup

  task automatic go;
    @(posedge mclk_i);
    fw_ret <= 1'b1;
    @(posedge mclk_i);
    fw_ret <= 1'b0;
  endtask : go

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      #1;
      chk("drain idle", 64'h0, 64'(drain_req));
      chk("no take", 64'h0, 64'(take));
    end
  endtask : quiet

  task automatic wait_drain;
    int n;
    n = 0;
    while (drain_req !== 1'b1 && n < 30) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk("drain request", 64'h1, 64'(drain_req));
  endtask : wait_drain

  task automatic deliver(input logic [5:0] id);
    logic [63:0] d;
    int n;
    wait_drain();
    // Hold the pipeline busy so an early take shows
    repeat (3) begin
      @(posedge mclk_i);
      #1;
      chk("early take", 64'h0, 64'(take));
    end
    @(posedge mclk_i);
    drained <= 1'b1;
    n = 0;
    while (take !== 1'b1 && n < 5) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk("take", 64'h1, 64'(take));
    chk("firmware mode", 64'h1, 64'(fw_mode));
    @(posedge mclk_i);
    drained <= 1'b0;
    rd_reg(IDX_INT_ID, 1'b1, d);
    chk("identification", 64'(id), {58'h0, d[5:0]});
    rd_reg(IDX_EXCEPTION_RETURN_ADDRESS, 1'b1, d);
    chk("return address", {pc[63:1], 1'b0}, d);
  endtask : deliver

  task automatic halt_back;
    src(32, 1'b1);
    deliver(ID_HALT);
    src(32, 1'b0);
  endtask : halt_back

  initial begin
    #800000;
    n_errors++;
    test_done();
  end

  initial begin
    logic [63:0] d;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk("mode after reset", 64'h1, 64'(fw_mode));
    chk("drain after reset", 64'h0, 64'(drain_req));
    foreach (rows[k]) begin
      @(posedge mclk_i);
      pc <= 64'h89AB_CDEF_0000_1001 + 64'(k << 8);
      setup(5'(rows[k].cur), 4'hF);
      src(rows[k].tgt, 1'b1);
      go();
      if (rows[k].take)
        deliver(rows[k].tgt == 33 ? ID_SERIAL :
                rows[k].tgt == 34 ? 6'd31 : 6'(rows[k].tgt));
      else begin
        quiet(10);
        halt_back();
      end
      src(rows[k].tgt, 1'b0);
    end
    // Masked external line; move instructions ignored outside firmware
    setup(5'd0, 4'hE);
    src(20, 1'b1);
    go();
    quiet(10);
    rd_reg(IDX_CUR_LEVEL, 1'b0, d);
    wr_reg(IDX_CUR_LEVEL, 64'h1F);
    halt_back();
    src(20, 1'b0);
    rd_reg(IDX_CUR_LEVEL, 1'b1, d);
    chk("level unprivileged write", 64'h0, {59'h0, d[4:0]});
    // Held off in firmware mode, then the higher level wins
    setup(5'd0, 4'hF);
    src(21, 1'b1);
    src(30, 1'b1);
    quiet(8);
    rd_reg(IDX_SUMMARY, 1'b1, d);
    chk("summary", 64'h4020_0000, d & 64'h7_FFFF_FFFE);
    go();
    deliver(6'd30);
    src(21, 1'b0);
    src(30, 1'b0);
    // Request withdrawn while the pipeline drains
    setup(5'd0, 4'hF);
    src(31, 1'b1);
    go();
    wait_drain();
    src(31, 1'b0);
    repeat (5) @(posedge mclk_i);
    quiet(5);
    halt_back();
    // Straps sampled under reset; registers survive it
    wr_reg(IDX_CUR_LEVEL, 64'h7);
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    ext_src <= 8'h0A;
    pwr_src <= 1'b1;
    halt_src <= 1'b1;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    ext_src <= 8'h00;
    pwr_src <= 1'b0;
    halt_src <= 1'b0;
    @(posedge mclk_i);
    #1;
    chk("straps", 64'h5A, 64'(straps));
    rd_reg(IDX_CUR_LEVEL, 1'b1, d);
    chk("level kept", 64'h7, {59'h0, d[4:0]});
    test_done();
  end
endmodule : priority_interrupt_unit_tb
`default_nettype wire
